// ===== codec_test_pkg.sv
`default_nettype none
package codec_test_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_TEST_INPUT_BYTE0  = 10'h11e;
    localparam logic [9:0] IDX_TEST_INPUT_BYTE4  = 10'h122;
    localparam logic [9:0] IDX_TEST_INPUT_BYTE5  = 10'h123;
    localparam logic [9:0] IDX_TEST_INPUT_BYTE6  = 10'h124;
    localparam logic [9:0] IDX_CODEC_TEST_CTRL   = 10'h110;
    localparam logic [9:0] IDX_TEST_RESULT_BYTE0 = 10'h130;

    localparam int NUM_INPUT_BYTES  = 9;
    localparam int NUM_ENC_BYTES    = 8;
    localparam int NUM_RESULT_BYTES = 9;

    // ------------------------------------------------------------
    // Control fields and reset values
    // ------------------------------------------------------------
    localparam int POS_MANUAL_ECC_ENABLE = 0;
    localparam int POS_CODEC_PATH_SELECT = 1;
    localparam logic [1:0] RESET_CODEC_TEST_CTRL = 2'h0;
    localparam logic [7:0] RESET_TEST_INPUT_BYTE = 8'h00;

    localparam logic CODEC_PATH_DECODER = 1'b0;
    localparam logic CODEC_PATH_ENCODER = 1'b1;

endpackage
`default_nettype wire

// ===== test_byte_if.sv
`default_nettype none
interface test_byte_if;
    logic       wr_en;
    logic [7:0] wr_data;
    logic [7:0] value;

    modport store (input wr_en, input wr_data, output value);
    modport bank  (output wr_en, output wr_data, input value);
endinterface
`default_nettype wire

// ===== test_byte_reg.sv
`default_nettype none
module test_byte_reg
    import codec_test_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    test_byte_if.store         port
);

    logic [7:0] stored;
    logic [7:0] next_stored;

    always_comb
    begin
        next_stored = stored;
        if (port.wr_en)
        begin
            next_stored = port.wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stored <= RESET_TEST_INPUT_BYTE; // see (R05)
        end
        else
        begin
            stored <= next_stored;
        end
    end

    assign port.value = stored;

endmodule
`default_nettype wire

// ===== codec_test_bank.sv
// What this block does
// (R01) Test input bytes drive the codec only while manual-mode ECC is enabled.
// (R02) With path select at 1, bytes zero to seven go to the encoder.
// (R03) With path select at 0, bytes zero to eight go to the decoder.
// (R04) Software reads the result bytes back after loading inputs and checks them.
// (R05) Test input byte four is an 8-bit read/write register at index 0x122, reset to zero.
// (R06) In encoder mode byte eight is ignored and its stored value is left alone.
//
// Added by the designer: register access over APB.
`default_nettype none
module codec_test_bank
    import codec_test_pkg::*;
(
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [11:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    output logic [31:0]                                prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic [NUM_RESULT_BYTES-1:0][7:0]      codec_test_result_byte,
    output logic                                       enc_valid,
    output logic [NUM_ENC_BYTES-1:0][7:0]              enc_data,
    output logic                                       dec_valid,
    output logic [NUM_INPUT_BYTES-1:0][7:0]            dec_data
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [1:0]                             ctrl;
    logic [1:0]                             next_ctrl;
    logic [NUM_INPUT_BYTES-1:0][7:0]        codec_test_input_byte;
    logic [NUM_INPUT_BYTES-1:0]             byte_wr;
    logic [9:0]                             idx;
    logic                                   setup;
    logic                                   access_wr;
    logic [31:0]                            rd_word;
    logic [31:0]                            next_prdata;
    logic                                   rd_err;
    logic                                   next_pslverr;
    logic [9:0]                             in_off;
    logic [9:0]                             res_off;
    logic                                   manual_ecc_enable;
    logic                                   codec_path_select;

    test_byte_if byte_if [NUM_INPUT_BYTES] ();

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign idx       = paddr[11:2];
    assign setup     = psel && !penable;
    assign access_wr = psel && penable && pwrite;
    assign in_off    = idx - IDX_TEST_INPUT_BYTE0;
    assign res_off   = idx - IDX_TEST_RESULT_BYTE0;

    assign manual_ecc_enable = ctrl[POS_MANUAL_ECC_ENABLE];
    assign codec_path_select = ctrl[POS_CODEC_PATH_SELECT];

    // ------------------------------------------------------------
    // Test input bytes
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_INPUT_BYTES; g++)
        begin : g_byte
            // Each byte is an independent word; byte four lands on index 0x122
            assign byte_wr[g]            = access_wr && (in_off == 10'(g)); // see (R05)
            assign byte_if[g].wr_en      = byte_wr[g];
            assign byte_if[g].wr_data    = pwdata[7:0];
            assign codec_test_input_byte[g] = byte_if[g].value;
            test_byte_reg u_byte (
                .pclk    (pclk),
                .presetn (presetn),
                .port    (byte_if[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_comb
    begin
        next_ctrl = ctrl;
        // Writes land even while a path is enabled
        if (access_wr && idx == IDX_CODEC_TEST_CTRL)
        begin
            next_ctrl = pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= RESET_CODEC_TEST_CTRL;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    // Decoded in setup so data leaves a flop with no wait state
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        if (idx == IDX_CODEC_TEST_CTRL)
        begin
            rd_word = {30'h0000_0000, ctrl};
        end
        else if (idx >= IDX_TEST_INPUT_BYTE0 && in_off < 10'(NUM_INPUT_BYTES))
        begin
            rd_word = {24'h00_0000, codec_test_input_byte[in_off[3:0]]};
        end
        else if (idx >= IDX_TEST_RESULT_BYTE0 && res_off < 10'(NUM_RESULT_BYTES))
        begin
            // Result bytes are what software compares against expectations
            rd_word = {24'h00_0000, codec_test_result_byte[res_off[3:0]]}; // see (R04)
        end
        else
        begin
            rd_err = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    always_comb
    begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setup)
        begin
            next_prdata  = pwrite ? 32'h0000_0000 : rd_word;
            next_pslverr = rd_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Ready
    // ------------------------------------------------------------
    // Zero wait states: data already loaded at setup
    assign pready = 1'b1;

    // ------------------------------------------------------------
    // Codec stimulus
    // ------------------------------------------------------------
    logic                               next_enc_valid;
    logic                               next_dec_valid;
    logic [NUM_ENC_BYTES-1:0][7:0]      next_enc_data;
    logic [NUM_INPUT_BYTES-1:0][7:0]    next_dec_data;

    // Idle paths are held at zero so the codec never sees stale bytes
    always_comb
    begin
        next_enc_valid = 1'b0;
        next_dec_valid = 1'b0;
        next_enc_data  = '0;
        next_dec_data  = '0;
        if (manual_ecc_enable) // see (R01)
        begin
            if (codec_path_select == CODEC_PATH_ENCODER)
            begin
                next_enc_valid = 1'b1;
                // Byte eight is not routed and is never rewritten here
                next_enc_data  = codec_test_input_byte[NUM_ENC_BYTES-1:0]; // see (R02) see (R06)
            end
            else
            begin
                next_dec_valid = 1'b1;
                next_dec_data  = codec_test_input_byte; // see (R03)
            end
        end
    end

    // ------------------------------------------------------------
    // Codec output registers
    // ------------------------------------------------------------
    // Registered so the codec never sees decode glitches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enc_valid <= 1'b0;
            dec_valid <= 1'b0;
            enc_data  <= '0;
            dec_data  <= '0;
        end
        else
        begin
            enc_valid <= next_enc_valid;
            dec_valid <= next_dec_valid;
            enc_data  <= next_enc_data;
            dec_data  <= next_dec_data;
        end
    end

endmodule
`default_nettype wire

// ===== codec_test_checker.sv
`default_nettype none
module codec_test_checker
    import codec_test_pkg::*;
(
    input wire logic                            pclk,
    input wire logic                            presetn,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [11:0]                     paddr,
    input wire logic [31:0]                     pwdata,
    input wire logic                            pready,
    input wire logic                            pslverr,
    input wire logic                            enc_valid,
    input wire logic [NUM_ENC_BYTES-1:0][7:0]   enc_data,
    input wire logic                            dec_valid,
    input wire logic [NUM_INPUT_BYTES-1:0][7:0] dec_data
);
    // ----
    // Decoded write strobe
    // ----
    logic       wr;
    logic [9:0] idx;
    assign wr  = psel && penable && pwrite;
    assign idx = paddr[11:2];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ONE_PATH: assert property (!(enc_valid && dec_valid))
        else $error("both codec paths valid");
    AST_ENC_IDLE: assert property (!enc_valid |-> enc_data == '0)
        else $error("encoder data not idle");
    AST_DEC_IDLE: assert property (!dec_valid |-> dec_data == '0)
        else $error("decoder data not idle");
    AST_ENC_ON: assert property (wr && idx == IDX_CODEC_TEST_CTRL && pwdata[1:0] == 2'h3
        |=> ##1 enc_valid)
        else $error("encoder path not enabled");
    AST_DEC_ON: assert property (wr && idx == IDX_CODEC_TEST_CTRL && pwdata[1:0] == 2'h1
        |=> ##1 dec_valid)
        else $error("decoder path not enabled");
    AST_BYTE4_ENC: assert property (wr && idx == IDX_TEST_INPUT_BYTE4 && enc_valid
        |=> ##1 enc_data[4] == $past(pwdata[7:0], 2))
        else $error("byte four not fed to encoder");
    AST_BYTE8_DEC: assert property (wr && idx == IDX_TEST_INPUT_BYTE0 + 10'h8 && dec_valid
        |=> ##1 dec_data[8] == $past(pwdata[7:0], 2))
        else $error("byte eight not fed to decoder");
    // Byte eight must not disturb the encoder view
    AST_BYTE8_ENC: assert property (wr && idx == IDX_TEST_INPUT_BYTE0 + 10'h8 && enc_valid
        |=> ##1 $stable(enc_data))
        else $error("byte eight reached encoder");
    AST_UNMAPPED: assert property (psel && penable && idx == 10'h3ff |-> pslverr && pready)
        else $error("unmapped access not refused");
endmodule

bind codec_test_bank codec_test_checker u_codec_test_checker (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .enc_valid, .enc_data, .dec_valid, .dec_data);
`default_nettype wire

// ===== tb.sv
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb
    import codec_test_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                             pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic                             enc_valid, dec_valid;
    logic [11:0]                      paddr;
    logic [31:0]                      pwdata, prdata, rd;
    logic [NUM_RESULT_BYTES-1:0][7:0] res;
    logic [NUM_ENC_BYTES-1:0][7:0]    enc_data;
    logic [NUM_INPUT_BYTES-1:0][7:0]  dec_data;
    int                               n_mismatch, tests_run;

    codec_test_bank u_codec_test_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .codec_test_result_byte(res), .enc_valid, .enc_data,
        .dec_valid, .dec_data);

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ----
    // Bus access and helpers
    // ----
    task automatic results;
        $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Starts on a fresh edge so back-to-back calls never drive twice at once
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {a, 2'b00};
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            results();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    // ----
    // Main sequence
    // ----
    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        res     = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK("enc valid reset", 1'b0, enc_valid)
        `CHK("dec valid reset", 1'b0, dec_valid)
        apb(1'b0, IDX_CODEC_TEST_CTRL, 8'h0);
        `CHK("control reset", 32'h0, rd)
        `CHK("mapped read err", 1'b0, err)
        for (int n = 0; n < 9; n++)
        begin
            apb(1'b0, IDX_TEST_INPUT_BYTE0 + 10'(n), 8'h0);
            `CHK("input byte reset", 32'h0, rd)
            apb(1'b1, IDX_TEST_INPUT_BYTE0 + 10'(n), 8'ha0 + 8'(n));
        end
        for (int n = 0; n < 9; n++)
        begin
            apb(1'b0, IDX_TEST_INPUT_BYTE0 + 10'(n), 8'h0);
            `CHK("input byte", 32'(8'ha0 + 8'(n)), rd)
        end
        $display("Test register map done");
        apb(1'b1, IDX_CODEC_TEST_CTRL, 8'h2);
        settle();
        `CHK("enc valid off", 1'b0, enc_valid)
        `CHK("dec valid off", 1'b0, dec_valid)
        `CHK("enc data off", 64'h0, enc_data)
        apb(1'b1, IDX_CODEC_TEST_CTRL, 8'h3);
        apb(1'b1, IDX_TEST_INPUT_BYTE0 + 10'h8, 8'h5c);
        settle();
        `CHK("enc valid", 1'b1, enc_valid)
        `CHK("dec valid", 1'b0, dec_valid)
        for (int n = 0; n < 8; n++)
            `CHK("enc byte", 8'ha0 + 8'(n), enc_data[n])
        `CHK("dec data idle", 72'h0, dec_data)
        apb(1'b1, IDX_TEST_INPUT_BYTE4, 8'h4b);
        settle();
        `CHK("enc byte four", 8'h4b, enc_data[4])
        apb(1'b1, IDX_TEST_INPUT_BYTE4, 8'ha4);
        apb(1'b0, IDX_TEST_INPUT_BYTE0 + 10'h8, 8'h0);
        `CHK("byte eight kept", 32'h5c, rd)
        apb(1'b1, IDX_CODEC_TEST_CTRL, 8'h1);
        settle();
        `CHK("dec valid", 1'b1, dec_valid)
        `CHK("enc valid", 1'b0, enc_valid)
        `CHK("enc data idle", 64'h0, enc_data)
        for (int n = 0; n < 9; n++)
            `CHK("dec byte", (n == 8) ? 8'h5c : 8'ha0 + 8'(n), dec_data[n])
        apb(1'b1, IDX_TEST_INPUT_BYTE0 + 10'h8, 8'hc5);
        settle();
        `CHK("dec byte eight", 8'hc5, dec_data[8])
        apb(1'b1, IDX_CODEC_TEST_CTRL, 8'h0);
        settle();
        `CHK("dec valid off", 1'b0, dec_valid)
        `CHK("dec data off", 72'h0, dec_data)
        $display("Test codec paths done");
        @(posedge pclk);
        for (int n = 0; n < 9; n++)
            res[n] <= 8'h30 + 8'(n);
        for (int n = 0; n < 9; n++)
        begin
            apb(1'b0, IDX_TEST_RESULT_BYTE0 + 10'(n), 8'h0);
            `CHK("result byte", 32'(8'h30 + 8'(n)), rd)
        end
        apb(1'b1, 10'h3ff, 8'hff);
        `CHK("unmapped write err", 1'b1, err)
        apb(1'b0, 10'h3ff, 8'h0);
        `CHK("unmapped read err", 1'b1, err)
        `CHK("unmapped read data", 32'h0, rd)
        $display("Test readback done");
        apb(1'b1, IDX_CODEC_TEST_CTRL, 8'h3);
        settle();
        `CHK("enc valid before reset", 1'b1, enc_valid)
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK("enc valid after reset", 1'b0, enc_valid)
        `CHK("enc data after reset", 64'h0, enc_data)
        apb(1'b0, IDX_CODEC_TEST_CTRL, 8'h0);
        `CHK("control after reset", 32'h0, rd)
        apb(1'b0, IDX_TEST_INPUT_BYTE4, 8'h0);
        `CHK("byte four after reset", 32'h0, rd)
        $display("Test mid-run reset done");
        results();
    end
endmodule
`default_nettype wire
